// *** shared/lcs_consts.vh ***
// constants for the lithium charger sequencer
// assumes a 200 MHz core clock and the serial register port
`ifndef LCS_CONSTS_VH
`define LCS_CONSTS_VH
// ----------------------------------------
// register map
// ----------------------------------------
`define LCS_DEV_ADDR 7'h60
`define LCS_CTL_OFF 8'h01
`define LCS_SPV_OFF 8'h02
`define LCS_IRQ_OFF 8'h04
`define LCS_CTL_RESET 8'h43
`define LCS_SPV_RESET 3'h6
`define LCS_CTL_VTERM_HI 7
`define LCS_CTL_VTERM_LO 6
`define LCS_CTL_ICC_HI 5
`define LCS_CTL_ICC_LO 2
`define LCS_CTL_EN 1
`define LCS_CTL_EOC 0
`define LCS_SPV_RANGE 3
`define LCS_IRQ_TMO 0
// ----------------------------------------
// charge state codes
// ----------------------------------------
`define LCS_ST_OFF 3'h0
`define LCS_ST_PREQ 3'h1
`define LCS_ST_CC 3'h2
`define LCS_ST_CV 3'h3
`define LCS_ST_TFLT 3'h4
`define LCS_ST_DONE 3'h5
`define LCS_ST_TMO 3'h6
`define LCS_ST_TOP 3'h7
// ----------------------------------------
// timing
// ----------------------------------------
`define LCS_CLK_MHZ 200
`define LCS_BLINK_MS 1000
`define LCS_HALF_CYC (`LCS_CLK_MHZ * 1000 * `LCS_BLINK_MS / 2)
`define LCS_TOPOFF_MIN 21
`define LCS_PREQ_HOURS 1
`define LCS_SAFE_HOURS 10
`define LCS_TOPOFF_TICKS (`LCS_TOPOFF_MIN * 60 * 2)
`define LCS_PREQ_TICKS (`LCS_PREQ_HOURS * 3600 * 2)
`define LCS_SAFE_TICKS (`LCS_SAFE_HOURS * 3600 * 2)
`define LCS_USB_PREQ_MA10 8'h05
`endif

// *** verilog/lcs_timebase.v ***
// half-second tick and 1 Hz blink phase for the charger
// assumes one core clock; all charger intervals count these ticks
`timescale 1ns/1ps
`default_nettype none
module lcs_timebase #(
  parameter HALF_CYC = 100000000
) (
  input wire core_clk,
  input wire nrst,
  output reg half_tick,
  output reg blink_phase
);
  reg [26:0] div_reg;
  // ----------------------------------------
  // divider
  // ----------------------------------------
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      div_reg <= 27'h0000000;
      half_tick <= 1'b0;
      blink_phase <= 1'b0;
    end else if (div_reg == HALF_CYC[26:0] - 27'h0000001) begin
      div_reg <= 27'h0000000;
      half_tick <= 1'b1;
      blink_phase <= ~blink_phase;
    end else begin
      div_reg <= div_reg + 27'h0000001;
      half_tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** verilog/lcs_i2c_port.v ***
// serial register port: two-wire slave with random multi-byte writes
// assumes external pull-ups; sda is open drain, driven low only
`timescale 1ns/1ps
`default_nettype none
`include "lcs_consts.vh"
module lcs_i2c_port (
  input wire core_clk,
  input wire nrst,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  output reg [7:0] reg_addr,
  output reg [7:0] wr_data,
  output reg wr_pulse,
  input wire [7:0] rd_data
);
  localparam P_IDLE = 3'h0;
  localparam P_ADDR = 3'h1;
  localparam P_REG = 3'h2;
  localparam P_WDAT = 3'h3;
  localparam P_RDAT = 3'h4;
  reg [2:0] scl_s, sda_s;
  reg scl_f, sda_f;
  reg [2:0] st_reg;
  reg [3:0] cnt_reg;
  reg [7:0] sh_reg, tx_reg;
  wire scl_nx = (scl_s[1] == scl_s[2]) ? scl_s[2] : scl_f;
  wire sda_nx = (sda_s[1] == sda_s[2]) ? sda_s[2] : sda_f;
  wire rise = scl_nx & ~scl_f;
  wire fall = ~scl_nx & scl_f;
  wire start = scl_f & scl_nx & sda_f & ~sda_nx;
  wire stop = scl_f & scl_nx & ~sda_f & sda_nx;
  // ----------------------------------------
  // byte engine
  // ----------------------------------------
  // a change counts only once the second and third stages agree
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      scl_f <= 1'b1;
      sda_f <= 1'b1;
      st_reg <= P_IDLE;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      tx_reg <= 8'h00;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      reg_addr <= 8'h00;
      wr_data <= 8'h00;
      wr_pulse <= 1'b0;
    end else begin
      scl_s <= {scl_s[1:0], scl_in};
      sda_s <= {sda_s[1:0], sda_in};
      scl_f <= scl_nx;
      sda_f <= sda_nx;
      wr_pulse <= 1'b0;
      if (start) begin
        st_reg <= P_ADDR;
        cnt_reg <= 4'h0;
        sda_oe <= 1'b0;
      end else if (stop) begin
        st_reg <= P_IDLE;
        sda_oe <= 1'b0;
      end else if (rise && st_reg != P_IDLE) begin
        if (cnt_reg != 4'h8) begin
          sh_reg <= {sh_reg[6:0], sda_nx};
          cnt_reg <= cnt_reg + 4'h1;
        end else begin
          cnt_reg <= 4'h0;
          // master nack ends a read
          if (st_reg == P_RDAT && sda_nx)
            st_reg <= P_IDLE;
          else
            tx_reg <= rd_data;
        end
      end else if (fall && st_reg != P_IDLE) begin
        if (cnt_reg == 4'h8 && st_reg != P_RDAT) begin
          sda_oe <= 1'b1;
          case (st_reg)
            P_ADDR: begin
              if (sh_reg[7:1] == `LCS_DEV_ADDR) begin
                st_reg <= sh_reg[0] ? P_RDAT : P_REG;
                tx_reg <= rd_data;
              end else begin
                st_reg <= P_IDLE;
                sda_oe <= 1'b0;
              end
            end
            P_REG: begin
              reg_addr <= sh_reg;
              st_reg <= P_WDAT;
            end
            P_WDAT: begin
              wr_data <= sh_reg;
              wr_pulse <= 1'b1;
              st_reg <= P_REG;
            end
            default: st_reg <= P_IDLE;
          endcase
        end else if (cnt_reg == 4'h8) begin
          sda_oe <= 1'b0;
        end else begin
          sda_oe <= (st_reg == P_RDAT) & ~tx_reg[3'h7 - cnt_reg[2:0]];
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** verilog/lcs_charger.v ***
// charge sequencer top: registers, charge state machine, leds, safety timer
// assumes analog loops and comparators outside, each reporting a level
`timescale 1ns/1ps
`default_nettype none
`include "lcs_consts.vh"
// Functional notes
// RULE_01: adapter wins when both sources present
// RULE_02: leds off unpowered; red on otherwise
// RULE_03: green blinks 1 s during constant voltage
// RULE_04: green steady on in top-off, complete
// RULE_05: faults and timeout blink red, green off
// RULE_06: termination voltage from control bits 7:6
// RULE_07: full-rate current from control bits 5:2
// RULE_08: disabled charger reports state 000; code keeps state 101 when disabled in complete
// RULE_09: end-of-charge 5 or 10 percent, bit 0
// RULE_10: pre-qualification current, state 001
// RULE_11: full-rate threshold enters state 010
// RULE_12: termination voltage enters state 011
// RULE_13: end-of-charge current starts 21 minute top-off
// RULE_14: complete disables charging; restart on sag
// RULE_15: temperature window select, supervisor bit 3
// RULE_16: temperature outside window suspends, state 100
// RULE_17: prequal one hour; total ten hours
// RULE_18: timeout raises interrupt and sticky flag
// RULE_19: listed events clear the safety timer
// RULE_20: state code in supervisor bits 2:0
// RULE_21: one timebase for all intervals
module lcs_charger #(
  parameter HALF_CYC = `LCS_HALF_CYC
) (
  input wire core_clk,
  input wire nrst,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  input wire adapter_power_in,
  input wire usb_power_in,
  input wire usb_suspend_in,
  input wire above_fullrate_threshold,
  input wire at_term_voltage,
  input wire at_eoc_current,
  input wire below_restart_voltage,
  input wire temp_in_window50,
  input wire temp_in_window45,
  input wire thermal_shutdown_in,
  output reg red_led_drive,
  output reg green_led_drive,
  output reg charge_state_bit2,
  output reg charge_state_bit1,
  output reg charge_state_bit0,
  output reg charging_on,
  output reg source_usb_sel,
  output reg [1:0] term_voltage_sel,
  output reg eoc_sel_10pct,
  output reg [7:0] current_req_ma10,
  output reg irq_n
);
  localparam NSYNC = 10;
  localparam [16:0] SAFE_TICKS = `LCS_SAFE_TICKS;
  localparam [16:0] PREQ_TICKS = `LCS_PREQ_TICKS;
  localparam [11:0] TOP_TICKS = `LCS_TOPOFF_TICKS;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  wire [NSYNC-1:0] raw_in = {thermal_shutdown_in, temp_in_window45, temp_in_window50,
    below_restart_voltage, at_eoc_current, at_term_voltage, above_fullrate_threshold,
    usb_suspend_in, usb_power_in, adapter_power_in};
  wire [NSYNC-1:0] flt;
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      reg s1, s2, s3, f;
      always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          f <= 1'b0;
        end else begin
          s1 <= raw_in[gi];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3)
            f <= s3;
        end
      end
      assign flt[gi] = f;
    end
  endgenerate
  wire adp = flt[0];
  wire usb = flt[1];
  wire usb_susp = flt[2];
  wire v_full = flt[3];
  wire v_term = flt[4];
  wire i_eoc = flt[5];
  wire v_rst = flt[6];
  wire tw50 = flt[7];
  wire tw45 = flt[8];
  wire tsd = flt[9];

  // ----------------------------------------
  // register port and registers
  // ----------------------------------------
  wire [7:0] reg_addr, wr_data;
  wire wr_pulse;
  wire sda_out_w, sda_oe_w;
  reg [7:0] rd_data;
  reg [7:0] ctl_reg;
  reg [2:0] spv_reg;
  reg tmo_flag_reg;
  reg [2:0] state_reg, state_next;
  wire tmo_set;

  lcs_i2c_port u_port (
    .core_clk(core_clk),
    .nrst(nrst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out_w),
    .sda_oe(sda_oe_w),
    .reg_addr(reg_addr),
    .wr_data(wr_data),
    .wr_pulse(wr_pulse),
    .rd_data(rd_data)
  );

  // RULE_20: state code readback
  always @* begin
    case (reg_addr)
      `LCS_CTL_OFF: rd_data = ctl_reg;
      `LCS_SPV_OFF: rd_data = {2'b00, spv_reg, state_reg};
      `LCS_IRQ_OFF: rd_data = {7'h00, tmo_flag_reg};
      default: rd_data = 8'h00;
    endcase
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctl_reg <= `LCS_CTL_RESET;
      spv_reg <= `LCS_SPV_RESET;
      tmo_flag_reg <= 1'b0;
    end else begin
      if (wr_pulse && reg_addr == `LCS_CTL_OFF)
        ctl_reg <= wr_data;
      if (wr_pulse && reg_addr == `LCS_SPV_OFF)
        spv_reg <= wr_data[5:3];
      // RULE_18: sticky flag, set beats clear
      if (tmo_set)
        tmo_flag_reg <= 1'b1;
      else if (wr_pulse && reg_addr == `LCS_IRQ_OFF && wr_data[`LCS_IRQ_TMO])
        tmo_flag_reg <= 1'b0;
    end
  end

  wire ctl_en = ctl_reg[`LCS_CTL_EN];
  wire [3:0] icc_code = ctl_reg[`LCS_CTL_ICC_HI:`LCS_CTL_ICC_LO];

  // ----------------------------------------
  // timebase
  // ----------------------------------------
  wire half_tick, blink_phase;
  // RULE_21: shared half-second tick
  lcs_timebase #(
    .HALF_CYC(HALF_CYC)
  ) u_tb (
    .core_clk(core_clk),
    .nrst(nrst),
    .half_tick(half_tick),
    .blink_phase(blink_phase)
  );

  // ----------------------------------------
  // source and fault conditions
  // ----------------------------------------
  // RULE_01: adapter has precedence
  wire pwr = adp | usb;
  wire src_usb = usb & ~adp;
  // RULE_15: window select
  wire temp_ok = spv_reg[0] ? tw45 : tw50;
  // RULE_16: outside window is a fault
  wire temp_flt = ~temp_ok | tsd;
  reg pwr_d, src_d, en_d, tsd_d, tflt_d, susp_d;
  reg [16:0] safe_cnt_reg;
  reg [11:0] top_cnt_reg;
  wire active = (state_reg == `LCS_ST_PREQ) | (state_reg == `LCS_ST_CC) |
    (state_reg == `LCS_ST_CV) | (state_reg == `LCS_ST_TOP);
  wire restart_sag = (state_reg == `LCS_ST_DONE) & v_rst & ctl_en;
  // RULE_19: safety timer restart events
  wire safe_clr = (pwr & ~pwr_d) | (pwr & pwr_d & (src_usb != src_d)) | restart_sag |
    (ctl_en & ~en_d) | (~tsd & tsd_d) | (~temp_flt & tflt_d & ctl_en) |
    (~usb_susp & susp_d & src_usb);
  // RULE_17: prequal and total limits
  wire safe_exp = (state_reg == `LCS_ST_PREQ) ? (safe_cnt_reg >= PREQ_TICKS) :
    (safe_cnt_reg >= SAFE_TICKS);
  assign tmo_set = active & safe_exp & ~safe_clr;

  // ----------------------------------------
  // charge state machine
  // ----------------------------------------
  always @* begin
    state_next = state_reg;
    if (!pwr) begin
      state_next = `LCS_ST_OFF;
    end else if (state_reg == `LCS_ST_DONE) begin
      // RULE_14: complete ignores enable until sag
      if (restart_sag)
        state_next = `LCS_ST_CC;
    end else if (!ctl_en) begin
      // RULE_08: disabled reports off
      state_next = `LCS_ST_OFF;
    end else if (temp_flt) begin
      state_next = `LCS_ST_TFLT;
    end else if (tmo_set) begin
      state_next = `LCS_ST_TMO;
    end else begin
      case (state_reg)
        `LCS_ST_OFF: state_next = `LCS_ST_PREQ;
        `LCS_ST_TFLT: state_next = `LCS_ST_PREQ;
        `LCS_ST_TMO: begin
          if (safe_clr)
            state_next = `LCS_ST_PREQ;
        end
        // RULE_11: full-rate threshold
        `LCS_ST_PREQ: begin
          if (v_full)
            state_next = `LCS_ST_CC;
        end
        // RULE_12: termination voltage reached
        `LCS_ST_CC: begin
          if (v_term)
            state_next = `LCS_ST_CV;
        end
        // RULE_13: end-of-charge begins top-off
        `LCS_ST_CV: begin
          if (i_eoc)
            state_next = `LCS_ST_TOP;
        end
        `LCS_ST_TOP: begin
          if (top_cnt_reg >= TOP_TICKS)
            state_next = `LCS_ST_DONE;
        end
        default: state_next = `LCS_ST_OFF;
      endcase
    end
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= `LCS_ST_OFF;
      pwr_d <= 1'b0;
      src_d <= 1'b0;
      en_d <= 1'b0;
      tsd_d <= 1'b0;
      tflt_d <= 1'b0;
      susp_d <= 1'b0;
      safe_cnt_reg <= 17'h00000;
      top_cnt_reg <= 12'h000;
    end else begin
      state_reg <= state_next;
      pwr_d <= pwr;
      src_d <= src_usb;
      en_d <= ctl_en;
      tsd_d <= tsd;
      tflt_d <= temp_flt;
      susp_d <= usb_susp;
      // RULE_19: clear and count from zero
      if (safe_clr)
        safe_cnt_reg <= 17'h00000;
      else if (active && half_tick && !safe_exp)
        safe_cnt_reg <= safe_cnt_reg + 17'h00001;
      // RULE_13: top-off interval
      if (state_reg != `LCS_ST_TOP)
        top_cnt_reg <= 12'h000;
      else if (half_tick)
        top_cnt_reg <= top_cnt_reg + 12'h001;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // leds and current request are registered so pins never glitch
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      red_led_drive <= 1'b0;
      green_led_drive <= 1'b0;
      charge_state_bit2 <= 1'b0;
      charge_state_bit1 <= 1'b0;
      charge_state_bit0 <= 1'b0;
      charging_on <= 1'b0;
      source_usb_sel <= 1'b0;
      term_voltage_sel <= 2'h1;
      eoc_sel_10pct <= 1'b1;
      current_req_ma10 <= 8'h00;
      irq_n <= 1'b1;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      sda_out <= sda_out_w;
      sda_oe <= sda_oe_w;
      {charge_state_bit2, charge_state_bit1, charge_state_bit0} <= state_reg;
      charging_on <= active;
      source_usb_sel <= src_usb;
      // RULE_06: termination select
      term_voltage_sel <= ctl_reg[`LCS_CTL_VTERM_HI:`LCS_CTL_VTERM_LO];
      // RULE_09: end-of-charge select
      eoc_sel_10pct <= ctl_reg[`LCS_CTL_EOC];
      // RULE_18: interrupt pin follows flag
      irq_n <= ~(tmo_flag_reg | tmo_set);
      if (state_reg == `LCS_ST_PREQ)
        // RULE_10: prequal current by source
        current_req_ma10 <= src_usb ? `LCS_USB_PREQ_MA10 : {4'h0, icc_code} + 8'h01;
      else if (active)
        // RULE_07: full rate in 100 mA steps
        current_req_ma10 <= ({4'h0, icc_code} + 8'h01) * 8'h0A;
      else
        current_req_ma10 <= 8'h00;
      if (!pwr) begin
        // RULE_02: no source, leds off
        red_led_drive <= 1'b0;
        green_led_drive <= 1'b0;
      end else if (state_reg == `LCS_ST_TFLT || state_reg == `LCS_ST_TMO) begin
        // RULE_05: red blink on fault
        red_led_drive <= blink_phase;
        green_led_drive <= 1'b0;
      end else begin
        // RULE_02: red on when powered
        red_led_drive <= 1'b1;
        if (state_reg == `LCS_ST_CV)
          // RULE_03: green blink in cv
          green_led_drive <= blink_phase;
        else
          // RULE_04: green steady when full
          green_led_drive <= (state_reg == `LCS_ST_TOP) | (state_reg == `LCS_ST_DONE);
      end
    end
  end
endmodule
`default_nettype wire

// *** verilog/lcs_charger_note_unused.v ***
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// *** sim/lcs_charger_assertions.sv ***
// checker for the charger sequencer outputs
// assumes a bind into lcs_charger, one clock domain
`timescale 1ns/1ps
`default_nettype none
module lcs_charger_assertions (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic adapter_power_in,
  input wire logic usb_power_in,
  input wire logic red_led_drive,
  input wire logic green_led_drive,
  input wire logic charge_state_bit2,
  input wire logic charge_state_bit1,
  input wire logic charge_state_bit0,
  input wire logic charging_on,
  input wire logic source_usb_sel,
  input wire logic [7:0] current_req_ma10,
  input wire logic irq_n
);
  // ----
  // properties
  // ----
  wire logic [2:0] st = {charge_state_bit2, charge_state_bit1, charge_state_bit0};
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // inputs cross a 3-flop sync, so eight cycles of a level covers the lag
  chk_adapter_wins: assert property (
    adapter_power_in [*8] |-> !source_usb_sel) else $error("usb chosen over adapter");
  chk_no_power_dark: assert property (
    (!adapter_power_in && !usb_power_in) [*8] |-> !red_led_drive && !green_led_drive)
    else $error("led lit without power");
  // two cycles of a state give the led and state registers one cycle of slack
  chk_top_green_on: assert property (
    ((st == 3'h7 || st == 3'h5) && (adapter_power_in || usb_power_in)) [*2] |-> green_led_drive)
    else $error("green off when full");
  chk_fault_green_off: assert property (
    (st == 3'h4 || st == 3'h6) [*2] |-> !green_led_drive && !charging_on)
    else $error("fault not suspended");
  chk_off_idle: assert property (
    (st == 3'h0) [*2] |-> !charging_on && current_req_ma10 == 8'h00)
    else $error("charging while off");
  chk_done_idle: assert property (
    (st == 3'h5) [*2] |-> !charging_on && current_req_ma10 == 8'h00)
    else $error("charging when complete");
  chk_usb_prequal: assert property (
    (st == 3'h1 && source_usb_sel) [*2] |-> charging_on && current_req_ma10 == 8'h05)
    else $error("usb prequal current wrong");
  chk_irq_timeout: assert property (
    $rose(st == 3'h6) |-> ##[0:3] !irq_n) else $error("no interrupt on timeout");
  cov_topoff: cover property (st == 3'h7);
  cov_timeout: cover property (st == 3'h6);
  cov_temp_fault: cover property (st == 3'h4);
endmodule
bind lcs_charger lcs_charger_assertions i_chk (.core_clk(core_clk), .nrst(nrst),
  .adapter_power_in(adapter_power_in), .usb_power_in(usb_power_in),
  .red_led_drive(red_led_drive), .green_led_drive(green_led_drive),
  .charge_state_bit2(charge_state_bit2), .charge_state_bit1(charge_state_bit1),
  .charge_state_bit0(charge_state_bit0), .charging_on(charging_on),
  .source_usb_sel(source_usb_sel), .current_req_ma10(current_req_ma10), .irq_n(irq_n));
`default_nettype wire

// *** sim/lcs_batt_model.sv ***
// cell comparators and status led meter for the charger bench
// assumes the bench sets the charge stage of the cell
`timescale 1ns/1ps
`default_nettype none
module lcs_batt_model (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [2:0] stage,
  input wire logic red_led_drive,
  input wire logic green_led_drive,
  output logic above_fullrate_threshold,
  output logic at_term_voltage,
  output logic at_eoc_current,
  output logic below_restart_voltage,
  output logic [15:0] green_on_len,
  output logic [15:0] red_off_len
);
  // ----
  // cell comparators
  // ----
  // stage 0 deep, 1 bulk, 2 at termination, 3 tapered, 4 sagged after charge
  assign above_fullrate_threshold = stage != 3'h0;
  assign at_term_voltage = stage == 3'h2 || stage == 3'h3;
  assign at_eoc_current = stage == 3'h3;
  assign below_restart_voltage = stage != 3'h2 && stage != 3'h3;
  // ----
  // led run lengths
  // ----
  // only the last complete run is kept; a long dark spell wraps harmlessly
  logic [15:0] g_run;
  logic [15:0] r_run;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      g_run <= 16'h0000;
      r_run <= 16'h0000;
      green_on_len <= 16'h0000;
      red_off_len <= 16'h0000;
    end else begin
      g_run <= green_led_drive ? g_run + 16'h0001 : 16'h0000;
      r_run <= red_led_drive ? 16'h0000 : r_run + 16'h0001;
      if (!green_led_drive && g_run != 16'h0000) green_on_len <= g_run;
      if (red_led_drive && r_run != 16'h0000) red_off_len <= r_run;
    end
  end
endmodule
`default_nettype wire

// *** sim/test_lcs_charger.sv ***
// self-checking bench for the charger sequencer
// assumes a pulled-up serial bus and a shortened timebase
`timescale 1ns/1ps
`default_nettype none
`include "lcs_consts.vh"
module test_lcs_charger;
  // ----
  // signals
  // ----
  localparam int HC = 4;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic scl = 1'b1;
  logic m_sda = 1'b1;
  logic adp = 1'b0;
  logic usb = 1'b0;
  logic t45 = 1'b1;
  logic t50 = 1'b1;
  logic tsd = 1'b0;
  logic susp = 1'b0;
  logic [2:0] stage = 3'h0;
  wire logic dut_oe, red, green, b2, b1, b0, chg_on, usb_sel, eoc, irq_n, afr, atv, aeoc, brs;
  wire logic dut_out;
  wire logic [1:0] tv;
  wire logic [7:0] cur;
  wire logic [15:0] g_len, r_len;
  wire logic [2:0] st = {b2, b1, b0};
  // a released line floats high through the pull-up
  wire logic sda_line = m_sda & ~(dut_oe & ~dut_out);
  logic [15:0] exp_q[$], obs_q[$];
  event obs_ev;
  int bad_count = 0;
  int checks = 0;
  int seed = 35;
  int cnt, rnd;
  logic [3:0] code;
  logic [7:0] v, rd_v;
  logic [8:0] r9;
  lcs_charger #(.HALF_CYC(HC)) i_dut (.core_clk(core_clk), .nrst(nrst), .scl_in(scl),
    .sda_in(sda_line), .sda_out(dut_out), .sda_oe(dut_oe), .adapter_power_in(adp),
    .usb_power_in(usb), .usb_suspend_in(susp), .above_fullrate_threshold(afr),
    .at_term_voltage(atv), .at_eoc_current(aeoc), .below_restart_voltage(brs),
    .temp_in_window50(t50), .temp_in_window45(t45), .thermal_shutdown_in(tsd),
    .red_led_drive(red), .green_led_drive(green), .charge_state_bit2(b2),
    .charge_state_bit1(b1), .charge_state_bit0(b0), .charging_on(chg_on),
    .source_usb_sel(usb_sel), .term_voltage_sel(tv), .eoc_sel_10pct(eoc),
    .current_req_ma10(cur), .irq_n(irq_n));
  lcs_batt_model i_batt (.core_clk(core_clk), .nrst(nrst), .stage(stage),
    .red_led_drive(red), .green_led_drive(green), .above_fullrate_threshold(afr),
    .at_term_voltage(atv), .at_eoc_current(aeoc), .below_restart_voltage(brs),
    .green_on_len(g_len), .red_off_len(r_len));
  // ----
  // tasks
  // ----
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic check(input logic [15:0] e, input logic [15:0] o);
    exp_q.push_back(e);
    obs_q.push_back(o);
    -> obs_ev;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wait_st(input logic [2:0] s, input int lim);
    cnt = 0;
    while (st !== s && cnt < lim) begin
      tick(1);
      cnt++;
    end
    if (st !== s) begin
      bad_count++;
      $display("MISMATCH at %0t: state %h never reached %h", $time, st, s);
      wrap_up();
    end
  endtask
  // one signal changes per step, so sda moves while scl is high only in start and stop
  task automatic bus(input logic c, input logic d);
    scl = c;
    m_sda = d;
    tick(8);
  endtask
  task automatic i2c_start;
    bus(1'b0, 1'b1);
    bus(1'b1, 1'b1);
    bus(1'b1, 1'b0);
    bus(1'b0, 1'b0);
  endtask
  task automatic i2c_stop;
    bus(1'b0, 1'b0);
    bus(1'b1, 1'b0);
    bus(1'b1, 1'b1);
  endtask
  task automatic xfer(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      bus(1'b0, d[i]);
      bus(1'b1, d[i]);
      r[i] = sda_line;
      bus(1'b0, d[i]);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i2c_start();
    xfer({`LCS_DEV_ADDR, 2'b01}, r9);
    xfer({a, 1'b1}, r9);
    xfer({d, 1'b1}, r9);
    i2c_stop();
  endtask
  task automatic rd(input logic [7:0] a);
    i2c_start();
    xfer({`LCS_DEV_ADDR, 2'b01}, r9);
    xfer({a, 1'b1}, r9);
    i2c_start();
    xfer({`LCS_DEV_ADDR, 2'b11}, r9);
    xfer(9'h1FF, r9);
    i2c_stop();
    rd_v = r9[8:1];
  endtask
  // ----
  // result monitor
  // ----
  always @(obs_ev) begin
    while (obs_q.size() > 0) begin
      checks++;
      if (obs_q[0] !== exp_q[0]) begin
        bad_count++;
        $display("MISMATCH at %0t: got %h expected %h", $time, obs_q[0], exp_q[0]);
      end
      void'(obs_q.pop_front());
      void'(exp_q.pop_front());
    end
  end
  // ----
  // stimulus
  // ----
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    tick(2);
    nrst = 1'b1;
    tick(10);
    rd(8'h01);
    check(16'h0043, 16'(rd_v));
    rd(8'h02);
    check(16'h0030, 16'(rd_v));
    rd(8'h07);
    check(16'h0000, 16'(rd_v));
    i2c_start();
    xfer(9'h091, r9);
    i2c_stop();
    check(16'h0001, 16'(r9[0]));
    check(16'h0000, 16'({red, green}));
    $display("test registers done");
    rnd = $random(seed);
    code = 4'((rnd & 32'h7FFFFFFF) % 10);
    v = {2'h2, code, 1'b1, rnd[8]};
    wr(8'h01, v);
    rd(8'h01);
    check(16'(v), 16'(rd_v));
    check(16'h0002, 16'(tv));
    check(16'(v[0]), 16'(eoc));
    adp = 1'b1;
    usb = 1'b1;
    wait_st(3'h1, 100);
    check(16'h0000, 16'(usb_sel));
    check(16'(code) + 16'h0001, 16'(cur));
    check(16'h0001, 16'(red));
    stage = 3'h1;
    wait_st(3'h2, 100);
    check((16'(code) + 16'h0001) * 16'h000A, 16'(cur));
    stage = 3'h2;
    wait_st(3'h3, 100);
    tick(10 * HC);
    check(16'(HC), g_len);
    check(16'h0001, 16'(red));
    stage = 3'h3;
    wait_st(3'h7, 100);
    wait_st(3'h5, 2520 * HC + 200);
    check(16'h0001, 16'(cnt > 2518 * HC - 8 && cnt < 2522 * HC + 8));
    check(16'h0001, 16'(green));
    wr(8'h01, v & 8'hFD);
    stage = 3'h4;
    tick(20);
    check(16'h0005, 16'(st));
    wr(8'h01, v);
    wait_st(3'h2, 100);
    stage = 3'h1;
    wr(8'h01, v & 8'hFD);
    wait_st(3'h0, 100);
    wr(8'h01, v);
    wait_st(3'h2, 100);
    $display("test charge cycle done");
    t50 = 1'b0;
    wait_st(3'h4, 100);
    t50 = 1'b1;
    wait_st(3'h2, 100);
    tsd = 1'b1;
    wait_st(3'h4, 100);
    tsd = 1'b0;
    wait_st(3'h2, 100);
    t45 = 1'b0;
    tick(40);
    check(16'h0002, 16'(st));
    wr(8'h02, 8'h38);
    wait_st(3'h4, 100);
    rd(8'h02);
    check(16'h003C, 16'(rd_v));
    check(16'(HC), r_len);
    check(16'h0000, 16'(green));
    t45 = 1'b1;
    wait_st(3'h2, 100);
    $display("test temperature done");
    adp = 1'b0;
    usb = 1'b0;
    stage = 3'h0;
    wait_st(3'h0, 100);
    usb = 1'b1;
    wait_st(3'h1, 100);
    check(16'h0001, 16'(usb_sel));
    check(16'h0005, 16'(cur));
    susp = 1'b1;
    tick(40);
    susp = 1'b0;
    wait_st(3'h6, 7200 * HC + 200);
    check(16'h0001, 16'(cnt > 7198 * HC - 8 && cnt < 7202 * HC + 8));
    tick(10 * HC);
    check(16'h0000, 16'(irq_n));
    rd(8'h04);
    check(16'h0001, 16'(rd_v));
    wr(8'h04, 8'h01);
    rd(8'h04);
    check(16'h0000, 16'(rd_v));
    check(16'h0001, 16'(irq_n));
    adp = 1'b1;
    wait_st(3'h1, 100);
    check(16'h0000, 16'(usb_sel));
    $display("test safety timer done");
    tick(1);
    wrap_up();
  end
endmodule
`default_nettype wire
